// file: shared/debug_event_router_defs.vh
// constants for the debug event router: map, fields, codes
`ifndef DEBUG_EVENT_ROUTER_DEFS_VH
`define DEBUG_EVENT_ROUTER_DEFS_VH

// ----------------------------------------------------------------
// comparator counts
// ----------------------------------------------------------------
`define NUM_BP        4
`define NUM_WP        2
`define BP_IDX_W      2
`define WP_IDX_W      1

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_BP_ADDR   8'h20
`define OFF_BP_CTL    8'h30
`define OFF_WP_ADDR   8'h40
`define OFF_WP_CTL    8'h48

// ----------------------------------------------------------------
// control register (external_debug_status_control) fields
// ----------------------------------------------------------------
`define CTRL_HALT_MODE 0
`define CTRL_EXC_EN_NS 1
`define CTRL_EXC_EN_S  2
`define CTRL_RESTART   8
`define CTRL_CLR_PEND  9
`define CTRL_RST       32'h0000_0000

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STAT_HALTED   0
`define STAT_PENDING  1
`define STAT_CAUSE_LO 4
`define STAT_ATTACHED 8
`define STAT_TRUSTED  9

// ----------------------------------------------------------------
// comparator control fields
// ----------------------------------------------------------------
`define CC_EN         0
`define CC_LINK       1
`define CC_VM_SEL     2
`define CC_IS_CTX     3
`define CC_LINK_LO    4
`define CC_LINK_HI    5
`define CC_EL_LO      6
`define CC_EL_HI      9
`define CC_SEC        10
`define CC_NS         11
`define CC_LOAD       12
`define CC_STORE      13
`define CC_RNG_LO     16
`define CC_RNG_HI     20
`define CC_RST        32'h0000_0000

// ----------------------------------------------------------------
// event cause codes
// ----------------------------------------------------------------
`define CAUSE_NONE    4'h0
`define CAUSE_HALT    4'h1
`define CAUSE_SWBP    4'h2
`define CAUSE_BP      4'h3
`define CAUSE_WP      4'h4
`define CAUSE_STEP    4'h5

`endif

// file: hdl/debug_event_router.v
// debug event router: comparators, event conversion, apb registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "debug_event_router_defs.vh"

module debug_event_router (
  // clock and reset
  input  wire        sys_clk,
  input  wire        srst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // external debugger pins
  input  wire        dbg_attached,
  input  wire        dbg_trusted,
  // core instruction side
  input  wire        instr_valid,
  input  wire [31:0] instr_addr,
  input  wire        halt_instruction,
  input  wire        breakpoint_instruction,
  input  wire        instr_64bit,
  input  wire        step_event,
  // core data side
  input  wire        data_valid,
  input  wire [31:0] data_addr,
  input  wire        data_load,
  input  wire        data_store,
  input  wire        data_fetch,
  // core context
  input  wire [1:0]  cur_el,
  input  wire        cur_secure,
  input  wire [31:0] cur_ctx_id,
  input  wire [7:0]  virtual_machine_identifier,
  // results to the core
  output wire        debug_exception,
  output wire        debug_state,
  output wire        irq_block,
  output wire [3:0]  event_cause
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a change counts once stages two and three agree
  reg [2:0] att_sync_reg;
  reg [2:0] tru_sync_reg;
  reg       attached_reg;
  reg       trusted_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      att_sync_reg <= 3'h0;
      tru_sync_reg <= 3'h0;
      attached_reg <= 1'b0;
      trusted_reg  <= 1'b0;
    end else begin
      att_sync_reg <= {att_sync_reg[1:0], dbg_attached};
      tru_sync_reg <= {tru_sync_reg[1:0], dbg_trusted};
      if (att_sync_reg[1] == att_sync_reg[2])
        attached_reg <= att_sync_reg[2];
      if (tru_sync_reg[1] == tru_sync_reg[2])
        trusted_reg <= tru_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [31:0] ctrl_reg;
  reg [31:0] bp_addr_reg [0:`NUM_BP-1];
  reg [31:0] bp_ctl_reg  [0:`NUM_BP-1];
  reg [31:0] wp_addr_reg [0:`NUM_WP-1];
  reg [31:0] wp_ctl_reg  [0:`NUM_WP-1];
  reg        halted_reg;
  reg        irq_block_reg;
  reg        pending_reg;
  reg [3:0]  cause_reg;
  reg        exc_reg;
  reg [31:0] prdata_reg;
  reg        pready_reg;
  reg        pslverr_reg;

  // a refused write must not land in any register
  wire       wr_en = psel & penable & pwrite & pready_reg & ~pslverr_reg;
  wire [7:0] abase = {paddr[7:4], 4'h0};
  // watchpoint address and control words share one 16-byte block
  wire [7:0] wbase = {paddr[7:3], 3'h0};

  // ----------------------------------------------------------------
  // security and enable qualification
  // ----------------------------------------------------------------
  // untrusted debugger may not halt a secure core
  wire halt_ok  = attached_reg & (~cur_secure | trusted_reg);
  wire exc_en   = cur_secure ? ctrl_reg[`CTRL_EXC_EN_S]
                             : ctrl_reg[`CTRL_EXC_EN_NS];
  wire halt_mode = ctrl_reg[`CTRL_HALT_MODE];

  // ----------------------------------------------------------------
  // breakpoint comparators
  // ----------------------------------------------------------------
  wire [`NUM_BP-1:0] ctx_hit;
  wire [`NUM_BP-1:0] bp_hit;

  genvar i;
  generate
    for (i = 0; i < `NUM_BP; i = i + 1) begin : g_bp
      wire [31:0] c = bp_ctl_reg[i];
      wire [3:0]  el_mask = c[`CC_EL_HI:`CC_EL_LO];
      wire qual = el_mask[cur_el] &
                  (cur_secure ? c[`CC_SEC] : c[`CC_NS]);
      // vm identifier match only in non-secure state
      wire vm_m = ~cur_secure &
                  (virtual_machine_identifier == bp_addr_reg[i][7:0]);
      wire id_m = (cur_ctx_id == bp_addr_reg[i]);
      assign ctx_hit[i] = c[`CC_EN] & c[`CC_IS_CTX] & qual &
                          (c[`CC_VM_SEL] ? vm_m : id_m);
      wire lnk_ok = ~c[`CC_LINK] |
                    ctx_hit[c[`CC_LINK_HI:`CC_LINK_LO]];
      assign bp_hit[i] = instr_valid & c[`CC_EN] & ~c[`CC_IS_CTX] &
                         qual & lnk_ok &
                         (instr_addr == bp_addr_reg[i]);
      always @(posedge sys_clk) begin
        if (srst) begin
          bp_addr_reg[i] <= 32'h0000_0000;
          bp_ctl_reg[i]  <= `CC_RST;
        end else if (wr_en) begin
          if (abase == `OFF_BP_ADDR && paddr[3:2] == i)
            bp_addr_reg[i] <= pwdata;
          else if (abase == `OFF_BP_CTL && paddr[3:2] == i)
            bp_ctl_reg[i] <= pwdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // watchpoint comparators
  // ----------------------------------------------------------------
  wire [`NUM_WP-1:0] wp_hit;

  generate
    for (i = 0; i < `NUM_WP; i = i + 1) begin : g_wp
      wire [31:0] c = wp_ctl_reg[i];
      wire [3:0]  el_mask = c[`CC_EL_HI:`CC_EL_LO];
      wire [4:0]  rng = c[`CC_RNG_HI:`CC_RNG_LO];
      // range: low address bits below rng are ignored
      wire [31:0] msk = ~((32'h0000_0001 << rng) - 32'h0000_0001);
      wire qual = el_mask[cur_el] &
                  (cur_secure ? c[`CC_SEC] : c[`CC_NS]);
      wire acc = (data_load & c[`CC_LOAD]) |
                 (data_store & c[`CC_STORE]);
      wire lnk_ok = ~c[`CC_LINK] |
                    ctx_hit[c[`CC_LINK_HI:`CC_LINK_LO]];
      assign wp_hit[i] = data_valid & ~data_fetch & c[`CC_EN] &
                         qual & acc & lnk_ok &
                         ((data_addr & msk) ==
                          (wp_addr_reg[i] & msk));
      always @(posedge sys_clk) begin
        if (srst) begin
          wp_addr_reg[i] <= 32'h0000_0000;
          wp_ctl_reg[i]  <= `CC_RST;
        end else if (wr_en) begin
          if (wbase == `OFF_WP_ADDR && paddr[2] == i)
            wp_addr_reg[i] <= pwdata;
          else if (wbase == `OFF_WP_CTL && paddr[2] == i)
            wp_ctl_reg[i] <= pwdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // event conversion
  // ----------------------------------------------------------------
  // one event per cycle by priority; each picks at most one action
  reg       go_exc;
  reg       go_halt;
  reg       go_pend;
  reg [3:0] ev_cause;

  always @* begin
    go_exc   = 1'b0;
    go_halt  = 1'b0;
    go_pend  = 1'b0;
    ev_cause = `CAUSE_NONE;
    // core is stopped in debug state, so events are not evaluated
    if (halted_reg) begin
      ev_cause = `CAUSE_NONE;
    end else if (instr_valid & breakpoint_instruction & instr_64bit) begin
      go_exc   = 1'b1;
      ev_cause = `CAUSE_SWBP;
    end else if (instr_valid & halt_instruction) begin
      go_halt  = halt_ok;
      ev_cause = `CAUSE_HALT;
    end else if ((|wp_hit) | (|bp_hit)) begin
      ev_cause = (|wp_hit) ? `CAUSE_WP : `CAUSE_BP;
      if (halt_mode & attached_reg) begin
        // refused halt is held until security allows it
        go_halt = halt_ok;
        go_pend = ~halt_ok;
      end else begin
        go_exc  = exc_en;
      end
    end else if (step_event) begin
      go_exc   = exc_en;
      ev_cause = `CAUSE_STEP;
    end
  end

  // pended event converts to debug state once allowed
  // yields to an exception in the same cycle and fires in the next cycle without one
  wire pend_fire = pending_reg & ~halted_reg & halt_ok & ~go_exc;
  wire restart   = wr_en & (paddr == `OFF_CTRL) & pwdata[`CTRL_RESTART];
  wire clr_pend  = wr_en & (paddr == `OFF_CTRL) & pwdata[`CTRL_CLR_PEND];

  always @(posedge sys_clk) begin
    if (srst) begin
      halted_reg    <= 1'b0;
      irq_block_reg <= 1'b0;
      pending_reg   <= 1'b0;
      cause_reg     <= `CAUSE_NONE;
      exc_reg       <= 1'b0;
    end else begin
      // exception pulse is registered in the event's cycle
      exc_reg <= go_exc & ~go_halt;
      if (go_halt | pend_fire) begin
        halted_reg    <= 1'b1;
        irq_block_reg <= 1'b1;
      end else if (restart & halted_reg) begin
        halted_reg    <= 1'b0;
        irq_block_reg <= 1'b0;
      end
      // a new pend wins over a software clear
      if (go_pend)
        pending_reg <= 1'b1;
      else if (pend_fire | clr_pend)
        pending_reg <= 1'b0;
      if (go_exc | go_halt | go_pend)
        cause_reg <= ev_cause;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  reg [31:0] rdata;
  reg        rerr;

  always @* begin
    rdata = 32'h0000_0000;
    rerr  = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rerr = 1'b1;
    end else if (paddr == `OFF_CTRL) begin
      rdata = {22'h0, 7'h0, ctrl_reg[`CTRL_EXC_EN_S:`CTRL_HALT_MODE]};
    end else if (paddr == `OFF_STATUS) begin
      rdata = {22'h0, trusted_reg, attached_reg, cause_reg,
               2'h0, pending_reg, halted_reg};
    end else if (abase == `OFF_BP_ADDR) begin
      rdata = bp_addr_reg[paddr[3:2]];
    end else if (abase == `OFF_BP_CTL) begin
      rdata = bp_ctl_reg[paddr[3:2]];
    end else if (abase == `OFF_WP_ADDR && ~paddr[3]) begin
      rdata = wp_addr_reg[paddr[2]];
    end else if (abase == `OFF_WP_ADDR && paddr[3]) begin
      rdata = wp_ctl_reg[paddr[2]];
    end else begin
      rerr = 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg    <= `CTRL_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      if (psel & penable & ~pready_reg) begin
        pready_reg  <= 1'b1;
        pslverr_reg <= rerr;
        prdata_reg  <= pwrite ? 32'h0000_0000 : rdata;
      end else begin
        pready_reg  <= 1'b0;
        pslverr_reg <= 1'b0;
      end
      // restart and clear bits are self-clearing commands
      if (wr_en & (paddr == `OFF_CTRL))
        ctrl_reg <= {29'h0, pwdata[`CTRL_EXC_EN_S:`CTRL_HALT_MODE]};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign debug_exception = exc_reg;
  assign debug_state     = halted_reg;
  assign irq_block       = irq_block_reg;
  assign event_cause     = cause_reg;

endmodule

// file: tb/router_chk.sv
// assertion checker for the debug event router ports
`timescale 1ns/1ps
`include "debug_event_router_defs.vh"
module router_chk (
  // clock and reset
  input wire        sys_clk,
  input wire        srst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  // debugger and core
  input wire        dbg_attached,
  input wire        instr_valid,
  input wire        breakpoint_instruction,
  input wire        instr_64bit,
  // results
  input wire        debug_exception,
  input wire        debug_state,
  input wire        irq_block,
  input wire [3:0]  event_cause
);
  wire swbp   = instr_valid & breakpoint_instruction & instr_64bit
                & ~debug_state;
  wire rst_wr = psel & penable & pready & pwrite & (paddr == `OFF_CTRL)
                & pwdata[`CTRL_RESTART];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  swbp_exc_a: assert property (swbp |=> debug_exception)
    else $error("breakpoint instruction gave no exception");
  swbp_nohalt_a: assert property (swbp |=> !debug_state)
    else $error("breakpoint instruction entered debug state");
  one_action_a: assert property (
    !(debug_exception && $rose(debug_state)))
    else $error("exception and debug state for one event");
  irq_block_a: assert property (irq_block == debug_state)
    else $error("interrupt block differs from debug state");
  stay_halted_a: assert property (debug_state && !rst_wr
    |=> debug_state)
    else $error("debug state left without restart");
  halted_ign_a: assert property (debug_state |=> !debug_exception)
    else $error("event converted while halted");
  exc_cause_a: assert property (debug_exception |-> event_cause inside
    {`CAUSE_SWBP, `CAUSE_BP, `CAUSE_WP, `CAUSE_STEP})
    else $error("exception with wrong cause");
  halt_attach_a: assert property ($rose(debug_state) |->
    $past(dbg_attached, 1) || $past(dbg_attached, 2) || $past(dbg_attached, 3)
    || $past(dbg_attached, 4) || $past(dbg_attached, 5)
    || $past(dbg_attached, 6))
    else $error("debug state entered with no debugger");
endmodule

// file: tb/jtag_host.sv
// external debugger host model: drives the attach and trust pins
`timescale 1ns/1ps
module jtag_host (
  // clock
  input  wire sys_clk,
  // commands from the bench
  input  wire connect,
  input  wire trust,
  // debugger pins
  output reg  dbg_attached,
  output reg  dbg_trusted
);
  initial begin
    dbg_attached = 1'b0;
    dbg_trusted  = 1'b0;
  end
  // pins move just after an edge; the router syncs them anyway
  always @(posedge sys_clk) begin
    dbg_attached <= connect;
    // trust without a cable means nothing
    dbg_trusted  <= connect & trust;
  end
endmodule

// file: tb/test_debug_event_router.sv
// self-checking testbench for the debug event router
`timescale 1ns/1ps
`include "debug_event_router_defs.vh"
module test_debug_event_router;
  reg          sys_clk, srst, psel, penable, pwrite, connect, trust;
  reg  [7:0]   paddr, virtual_machine_identifier;
  reg  [31:0]  pwdata, instr_addr, data_addr, cur_ctx_id;
  reg          instr_valid, halt_instruction, breakpoint_instruction;
  reg          instr_64bit, step_event, data_valid, data_load, data_store;
  reg          data_fetch, cur_secure;
  reg  [1:0]   cur_el;
  wire [31:0]  prdata;
  wire         pready, pslverr, dbg_attached, dbg_trusted;
  wire         debug_exception, debug_state, irq_block;
  wire [3:0]   event_cause;
  logic [31:0] q;
  logic        e;
  logic [31:0] bad [3];
  integer      n_errors, num_checks, i;

  debug_event_router uut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dbg_attached(dbg_attached), .dbg_trusted(dbg_trusted),
    .instr_valid(instr_valid), .instr_addr(instr_addr),
    .halt_instruction(halt_instruction),
    .breakpoint_instruction(breakpoint_instruction),
    .instr_64bit(instr_64bit), .step_event(step_event),
    .data_valid(data_valid), .data_addr(data_addr), .data_load(data_load),
    .data_store(data_store), .data_fetch(data_fetch), .cur_el(cur_el),
    .cur_secure(cur_secure), .cur_ctx_id(cur_ctx_id),
    .virtual_machine_identifier(virtual_machine_identifier),
    .debug_exception(debug_exception), .debug_state(debug_state),
    .irq_block(irq_block), .event_cause(event_cause));
  jtag_host host (.sys_clk(sys_clk), .connect(connect), .trust(trust),
    .dbg_attached(dbg_attached), .dbg_trusted(dbg_trusted));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("mismatch %s expected %h seen %h", n, x, g);
      end
    end
  endtask
  // one apb transfer; read data and error land in q and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // kinds: 1 halt, 2 swbp64, 3 plain, 4 ld, 5 st, 6 fetch, 7 step, 8 swbp32
  // a fetch is also a read, so only the fetch flag keeps watchpoints off
  task ev(input logic [3:0] k, input logic [31:0] a);
    begin
      @(posedge sys_clk);
      instr_addr             <= a;
      data_addr              <= a;
      instr_valid            <= (k <= 4'h3) || (k == 4'h8);
      halt_instruction       <= (k == 4'h1);
      breakpoint_instruction <= (k == 4'h2) || (k == 4'h8);
      instr_64bit            <= (k == 4'h2);
      data_valid             <= (k >= 4'h4) && (k <= 4'h6);
      data_load              <= (k == 4'h4) || (k == 4'h6);
      data_store             <= (k == 4'h5);
      data_fetch             <= (k == 4'h6);
      step_event             <= (k == 4'h7);
      @(posedge sys_clk);
      {instr_valid, halt_instruction, breakpoint_instruction, instr_64bit,
       data_valid, data_load, data_store, data_fetch, step_event} <= 9'h000;
      #1;
    end
  endtask
  task ob(input logic x, input logic s, input logic [3:0] c);
    begin
      chk("debug exception", {31'h0, x}, {31'h0, debug_exception});
      chk("debug state", {31'h0, s}, {31'h0, debug_state});
      chk("event cause", {28'h0, c}, {28'h0, event_cause});
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // the tests need well under a thousand cycles
  initial begin
    #200000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    n_errors = 0;
    num_checks = 0;
    {psel, penable, pwrite, connect, trust, instr_valid, halt_instruction,
     breakpoint_instruction, instr_64bit, step_event, data_valid, data_load,
     data_store, data_fetch, cur_secure} = 15'h0000;
    {paddr, pwdata, instr_addr, data_addr} = 104'h0;
    cur_el = 2'h1;
    cur_ctx_id = 32'h0000_0000;
    virtual_machine_identifier = 8'h00;
    bad = '{32'h0000_0F41, 32'h0000_07C1, 32'h0000_0FC0};
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk("ctrl reset", `CTRL_RST, q);
    apb(1'b0, `OFF_BP_CTL + 8'h0C, 32'h0);
    chk("last bp ctl", `CC_RST, q);
    apb(1'b0, `OFF_WP_CTL + 8'h04, 32'h0);
    chk("last wp ctl err", 32'h0, {31'h0, e});
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test reset done");
    ev(4'h2, 32'h0);
    ob(1'b1, 1'b0, `CAUSE_SWBP);
    ev(4'h8, 32'h0);
    ob(1'b0, 1'b0, `CAUSE_SWBP);
    ev(4'h7, 32'h0);
    ob(1'b0, 1'b0, `CAUSE_SWBP);
    apb(1'b1, `OFF_CTRL, 32'h0000_0002);
    ev(4'h7, 32'h0);
    ob(1'b1, 1'b0, `CAUSE_STEP);
    $display("test instructions done");
    apb(1'b1, `OFF_BP_ADDR, 32'h0000_1000);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b1, `OFF_BP_CTL, bad[i]);
      ev(4'h3, 32'h0000_1000);
      ob(1'b0, 1'b0, `CAUSE_STEP);
    end
    apb(1'b1, `OFF_BP_CTL, 32'h0000_0FC1);
    ev(4'h3, 32'h0000_1004);
    ob(1'b0, 1'b0, `CAUSE_STEP);
    ev(4'h3, 32'h0000_1000);
    ob(1'b1, 1'b0, `CAUSE_BP);
    apb(1'b1, `OFF_CTRL, 32'h0);
    ev(4'h3, 32'h0000_1000);
    ob(1'b0, 1'b0, `CAUSE_BP);
    apb(1'b1, `OFF_CTRL, 32'h0000_0002);
    // bp1 is a context comparator on the vm identifier; bp0 links to it
    apb(1'b1, `OFF_BP_ADDR + 8'h04, 32'h0000_0055);
    apb(1'b1, `OFF_BP_CTL + 8'h04, 32'h0000_0FCD);
    apb(1'b1, `OFF_BP_CTL, 32'h0000_0FD3);
    ev(4'h3, 32'h0000_1000);
    ob(1'b0, 1'b0, `CAUSE_BP);
    virtual_machine_identifier <= 8'h55;
    ev(4'h3, 32'h0000_1000);
    ob(1'b1, 1'b0, `CAUSE_BP);
    apb(1'b1, `OFF_BP_CTL, 32'h0000_0FC1);
    $display("test breakpoint done");
    apb(1'b1, `OFF_WP_ADDR, 32'h0000_2000);
    apb(1'b1, `OFF_WP_CTL, 32'h0000_1FC1);
    ev(4'h5, 32'h0000_2000);
    ob(1'b0, 1'b0, `CAUSE_BP);
    ev(4'h4, 32'h0000_2000);
    ob(1'b1, 1'b0, `CAUSE_WP);
    ev(4'h6, 32'h0000_2000);
    ob(1'b0, 1'b0, `CAUSE_WP);
    ev(4'h4, 32'h0000_2008);
    ob(1'b0, 1'b0, `CAUSE_WP);
    apb(1'b1, `OFF_WP_CTL, 32'h0004_2FD3);
    ev(4'h5, 32'h0000_200C);
    ob(1'b1, 1'b0, `CAUSE_WP);
    ev(4'h4, 32'h0000_2000);
    ob(1'b0, 1'b0, `CAUSE_WP);
    virtual_machine_identifier <= 8'h00;
    ev(4'h5, 32'h0000_200C);
    ob(1'b0, 1'b0, `CAUSE_WP);
    $display("test watchpoint done");
    apb(1'b1, `OFF_CTRL, 32'h0000_0001);
    ev(4'h1, 32'h0);
    ob(1'b0, 1'b0, `CAUSE_WP);
    connect <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ev(4'h1, 32'h0);
    ob(1'b0, 1'b1, `CAUSE_HALT);
    chk("irq block", 32'h1, {31'h0, irq_block});
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk("status halted", 32'h0000_0111, q);
    ev(4'h2, 32'h0);
    ob(1'b0, 1'b1, `CAUSE_HALT);
    apb(1'b1, `OFF_CTRL, 32'h0000_0101);
    @(posedge sys_clk);
    #1;
    chk("restart", 32'h0, {31'h0, debug_state});
    cur_secure <= 1'b1;
    ev(4'h1, 32'h0);
    ob(1'b0, 1'b0, `CAUSE_HALT);
    ev(4'h3, 32'h0000_1000);
    ob(1'b0, 1'b0, `CAUSE_BP);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk("pending", 32'h1, {31'h0, q[`STAT_PENDING]});
    apb(1'b1, `OFF_CTRL, 32'h0000_0201);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk("pend cleared", 32'h0, {31'h0, q[`STAT_PENDING]});
    ev(4'h3, 32'h0000_1000);
    ob(1'b0, 1'b0, `CAUSE_BP);
    trust <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    ob(1'b0, 1'b1, `CAUSE_BP);
    $display("test halting done");
    end_of_test;
  end
endmodule

bind debug_event_router router_chk chk (.sys_clk(sys_clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .dbg_attached(dbg_attached),
  .instr_valid(instr_valid),
  .breakpoint_instruction(breakpoint_instruction),
  .instr_64bit(instr_64bit), .debug_exception(debug_exception),
  .debug_state(debug_state), .irq_block(irq_block),
  .event_cause(event_cause));
